// ### rtl/acq_trig_consts.svh
// Constants for the acquisition trigger and buffer control block.
`ifndef ACQ_TRIG_CONSTS_SVH
`define ACQ_TRIG_CONSTS_SVH
// ----------------------------------------
// Widths and sizes
// ----------------------------------------
`define SAMPLE_W 24
`define LEVEL_W 14
`define IN_ADDR_W 10
`define OUT_ADDR_W 10
`define FIFO_DEPTH 16
`define CHAN_MAX 8
`define TBUS_LINES 6
`define LAN_EVENTS 8
// ----------------------------------------
// Threshold limits in millivolt codes of the level compare, and trigger bus pulse length
// ----------------------------------------
`define LEVEL_MIN_MV 14'h00C8
`define LEVEL_MAX_MV 14'h2648
`define HYST_MV 14'h0064
`define TBUS_PULSE_NS 100
`define TBUS_PULSE_CYC ((`TBUS_PULSE_NS + 9) / 10)
`endif

// ### rtl/acq_trig_pkg.sv
// Types shared by the acquisition trigger and buffer control block.
package acq_trig_pkg;
    typedef enum logic [2:0] {
        SRC_SOFTWARE,
        SRC_EXTERNAL,
        SRC_LEVEL,
        SRC_TBUS,
        SRC_LAN
    } trig_src_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN
    } sub_state_t;
endpackage

// ### rtl/sample_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wp_r] <= i_data;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_ready <= 1'b1;
        end else begin
            o_valid <= (cnt_r + (AW+1)'(push) - (AW+1)'(pop)) != '0;
            o_ready <= (cnt_r + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
        end
    end
    // Read data shows the head entry; it is read combinationally from the memory at the read pointer.
    assign o_data = mem_r[rp_r];
endmodule // sample_fifo

// ### rtl/sample_ram.sv
// Single-port-per-side sample memory with registered read data.
module sample_ram #(
    parameter int WIDTH = 24,
    parameter int AW = 10
) (
    // Clock
    input wire logic i_clk,
    // Write side
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    // Read side
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    logic [WIDTH-1:0] mem_r [2**AW];
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
    end
    always_ff @(posedge i_clk) begin
        o_rdata <= mem_r[i_raddr];
    end
endmodule // sample_ram

// ### rtl/acq_trigger_buffer_control.sv
// Trigger selection, start control and wrap/non-wrap buffering for input and output.
// What this block does
// - Software source: the start command itself triggers input conversions at once.
// - External source: trigger only on a rising edge of the trigger input.
// - Level source: channel one rising above programmed level, with hysteresis, triggers.
// - Bus source: one configured line of six bus lines triggers.
// - LAN source: the configured event number zero to seven triggers.
// - Input and output each hold their own trigger source selection.
// - One bus line may be chosen and driven as trigger output.
// - One LAN event may be chosen for broadcast as trigger packet.
// - Input wrap: pointer returns to start, oldest scans overwritten, runs on.
// - Input non-wrap: acquisition stops after the last whole scan that fits in the buffer.
// - Output wrap: read pointer returns to start, waveform repeats.
// - Output non-wrap: output stops after the entry at i_out_last.
// - Start commands for input alone, output alone, or both together.
// - Download returns samples from buffer start until stopped or the highest address written.
// - Digital output lines read back and individually opened or closed.
// - Input stored as scans of one sample per enabled channel, eight max.
`include "acq_trig_consts.svh"
module acq_trigger_buffer_control
    import acq_trig_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Configuration
    input wire logic [2:0] i_in_src,
    input wire logic [2:0] i_out_src,
    input wire logic [2:0] i_tbus_sel,
    input wire logic [2:0] i_lan_sel,
    input wire logic [2:0] i_tbus_out_sel,
    input wire logic i_tbus_out_en,
    input wire logic [2:0] i_lan_out_sel,
    input wire logic i_lan_out_en,
    input wire logic [`LEVEL_W-1:0] i_level_mv,
    input wire logic i_in_wrap,
    input wire logic i_out_wrap,
    input wire logic [7:0] i_chan_en,
    input wire logic [`OUT_ADDR_W-1:0] i_out_last,
    // Commands
    input wire logic i_arm_in,
    input wire logic i_arm_out,
    input wire logic i_start_in,
    input wire logic i_start_out,
    input wire logic i_stop,
    input wire logic i_dl_start,
    input wire logic i_dl_stop,
    // Trigger sources
    input wire logic i_ext_trig,
    input wire logic [`LEVEL_W-1:0] i_ch1_mv,
    input wire logic [5:0] i_tbus_in,
    input wire logic i_lan_evt_valid,
    input wire logic [2:0] i_lan_evt_num,
    // Sample stream, one channel sample per word in channel order
    input wire logic i_smp_valid,
    input wire logic [`SAMPLE_W-1:0] i_smp_data,
    output logic o_smp_ready,
    // Output waveform loading and stream
    input wire logic i_wav_we,
    input wire logic [`OUT_ADDR_W-1:0] i_wav_addr,
    input wire logic [`SAMPLE_W-1:0] i_wav_data,
    input wire logic i_dac_tick,
    output logic [`SAMPLE_W-1:0] o_dac_data,
    output logic o_dac_valid,
    // Download stream
    output logic o_dl_valid,
    output logic [`SAMPLE_W-1:0] o_dl_data,
    output logic o_dl_done,
    // Digital outputs
    input wire logic [3:0] i_dout_set,
    input wire logic [3:0] i_dout_val,
    output logic [3:0] o_dout_closed,
    // Trigger outputs and status
    output logic [5:0] o_tbus_out,
    output logic [5:0] o_tbus_oe_n,
    output logic o_lan_tx_valid,
    output logic [2:0] o_lan_tx_num,
    output logic [1:0] o_in_state,
    output logic [1:0] o_out_state,
    output logic o_in_full
);
    // ----------------------------------------
    // Trigger detection
    // ----------------------------------------
    sub_state_t in_st_r, out_st_r;
    logic ext_d_r, level_hi_r;
    logic [5:0] tbus_d_r;
    logic ext_rise, level_rise, level_hi_nxt;
    logic [5:0] tbus_rise;
    logic in_trig, out_trig, in_stop, out_stop;

    function automatic logic src_hit(input logic [2:0] src, input logic sw);
        unique case (trig_src_t'(src))
            SRC_SOFTWARE: src_hit = sw;
            SRC_EXTERNAL: src_hit = ext_rise;
            SRC_LEVEL: src_hit = level_rise;
            SRC_TBUS: src_hit = tbus_rise[i_tbus_sel];
            SRC_LAN: src_hit = i_lan_evt_valid && (i_lan_evt_num == i_lan_sel);
            default: src_hit = 1'b0;
        endcase
    endfunction

    assign ext_rise = i_ext_trig && !ext_d_r;
    assign tbus_rise = i_tbus_in & ~tbus_d_r;
    // Hysteresis keeps a noisy channel from retriggering: rearm only at or below level minus band.
    always_comb begin
        level_hi_nxt = level_hi_r;
        if (i_ch1_mv > i_level_mv) begin
            level_hi_nxt = 1'b1;
        end else if (15'(i_ch1_mv) + 15'(`HYST_MV) <= 15'(i_level_mv)) begin
            level_hi_nxt = 1'b0;
        end
    end
    assign level_rise = level_hi_nxt && !level_hi_r;
    // Level is clamped to its legal span by the host; out-of-span values are still honoured.
    assign in_trig = (in_st_r == ST_ARMED) && src_hit(i_in_src, i_start_in);
    assign out_trig = (out_st_r == ST_ARMED) && src_hit(i_out_src, i_start_out);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ext_d_r <= 1'b0;
            tbus_d_r <= '0;
            level_hi_r <= 1'b1;
        end else begin
            ext_d_r <= i_ext_trig;
            tbus_d_r <= i_tbus_in;
            level_hi_r <= level_hi_nxt;
        end
    end

    // ----------------------------------------
    // Subsystem state
    // ----------------------------------------
    logic in_done, out_done;
    always_ff @(posedge i_clk) begin
        if (i_rst || i_stop) begin
            in_st_r <= ST_IDLE;
        end else begin
            unique case (in_st_r)
                ST_IDLE: if (i_arm_in) in_st_r <= ST_ARMED;
                ST_ARMED: if (in_trig) in_st_r <= ST_RUN;
                ST_RUN: if (in_done) in_st_r <= ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst || i_stop) begin
            out_st_r <= ST_IDLE;
        end else begin
            unique case (out_st_r)
                ST_IDLE: if (i_arm_out) out_st_r <= ST_ARMED;
                ST_ARMED: if (out_trig) out_st_r <= ST_RUN;
                ST_RUN: if (out_done) out_st_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Input path: FIFO then scan memory
    // ----------------------------------------
    logic f_valid, f_ready;
    logic [`SAMPLE_W-1:0] f_data;
    logic [`IN_ADDR_W-1:0] wp_r, rp_r, hi_r;
    logic full_r;
    logic [`SAMPLE_W-1:0] in_rdata;
    logic [3:0] n_chan;
    logic [2:0] ch_r;
    logic wr_en;

    sample_fifo #(.WIDTH(`SAMPLE_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(i_smp_valid),
        .i_data(i_smp_data),
        .o_ready(f_ready),
        .o_valid(f_valid),
        .o_data(f_data),
        .i_ready(in_st_r == ST_RUN)
    );
    // Samples are drained only while running, so while armed the FIFO fills to 16 words and then stalls the source.
    assign wr_en = f_valid && (in_st_r == ST_RUN);
    assign n_chan = 4'($countones(i_chan_en));
    // Non-wrap stops after the last whole scan that fits, so no scan is torn or overwritten.
    assign in_done = wr_en && !i_in_wrap && (4'(ch_r) + 4'h1 >= n_chan)
        && ({1'b0, wp_r} + 11'(n_chan) > 11'h3FF);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wp_r <= '0;
            ch_r <= '0;
            full_r <= 1'b0;
            hi_r <= '0;
        end else begin
            if (in_st_r == ST_ARMED && in_trig) begin
                wp_r <= '0;
                ch_r <= '0;
                full_r <= 1'b0;
                hi_r <= '0;
            end else if (wr_en) begin
                wp_r <= wp_r + 1'b1;
                ch_r <= (4'(ch_r) + 4'h1 >= n_chan) ? 3'h0 : ch_r + 3'h1;
                if (wp_r == '1 || in_done) begin
                    full_r <= 1'b1;
                end
                if (!full_r && wp_r > hi_r) begin
                    hi_r <= wp_r;
                end
            end
        end
    end

    sample_ram #(.WIDTH(`SAMPLE_W), .AW(`IN_ADDR_W)) u_in_ram (
        .i_clk(i_clk),
        .i_we(wr_en),
        .i_waddr(wp_r),
        .i_wdata(f_data),
        .i_raddr(rp_r),
        .o_rdata(in_rdata)
    );

    // ----------------------------------------
    // Download
    // ----------------------------------------
    logic dl_act_r, dl_v_r;
    logic [`IN_ADDR_W-1:0] dl_end;
    assign dl_end = hi_r;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dl_act_r <= 1'b0;
            rp_r <= '0;
            dl_v_r <= 1'b0;
            o_dl_valid <= 1'b0;
            o_dl_done <= 1'b0;
        end else begin
            dl_v_r <= 1'b0;
            o_dl_valid <= dl_v_r;
            o_dl_done <= 1'b0;
            if (i_dl_start) begin
                dl_act_r <= 1'b1;
                rp_r <= '0;
            end else if (dl_act_r) begin
                dl_v_r <= 1'b1;
                if (i_dl_stop || rp_r == dl_end) begin
                    dl_act_r <= 1'b0;
                    o_dl_done <= 1'b1;
                end else begin
                    rp_r <= rp_r + 1'b1;
                end
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_dl_data <= '0;
        end else begin
            o_dl_data <= in_rdata;
        end
    end

    // ----------------------------------------
    // Output path
    // ----------------------------------------
    logic [`OUT_ADDR_W-1:0] op_r;
    logic [`SAMPLE_W-1:0] out_rdata;
    logic out_step;
    assign out_step = (out_st_r == ST_RUN) && i_dac_tick;
    assign out_done = out_step && !i_out_wrap && (op_r == i_out_last);
    always_ff @(posedge i_clk) begin
        if (i_rst || out_st_r != ST_RUN) begin
            op_r <= '0;
        end else if (out_step) begin
            op_r <= (op_r == i_out_last) ? '0 : op_r + 1'b1;
        end
    end
    sample_ram #(.WIDTH(`SAMPLE_W), .AW(`OUT_ADDR_W)) u_out_ram (
        .i_clk(i_clk),
        .i_we(i_wav_we),
        .i_waddr(i_wav_addr),
        .i_wdata(i_wav_data),
        .i_raddr(op_r),
        .o_rdata(out_rdata)
    );
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_dac_valid <= 1'b0;
            o_dac_data <= '0;
        end else begin
            o_dac_valid <= out_step;
            o_dac_data <= out_rdata;
        end
    end

    // ----------------------------------------
    // Trigger outputs, digital outputs, status
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tbus_out <= '0;
            o_tbus_oe_n <= '1;
            o_lan_tx_valid <= 1'b0;
            o_lan_tx_num <= '0;
        end else begin
            for (int i = 0; i < `TBUS_LINES; i++) begin
                o_tbus_oe_n[i] <= !(i_tbus_out_en && i_tbus_out_sel == 3'(i));
                o_tbus_out[i] <= in_trig && i_tbus_out_en && i_tbus_out_sel == 3'(i);
            end
            o_lan_tx_valid <= in_trig && i_lan_out_en;
            o_lan_tx_num <= i_lan_out_sel;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_dout_closed <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (i_dout_set[i]) begin
                    o_dout_closed[i] <= i_dout_val[i];
                end
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_in_state <= '0;
            o_out_state <= '0;
            o_in_full <= 1'b0;
        end else begin
            o_in_state <= in_st_r;
            o_out_state <= out_st_r;
            o_in_full <= full_r;
        end
    end
    // Ready is the FIFO's own flop; a delayed copy would let the source count a refused word.
    assign o_smp_ready = f_ready;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_ext_edge: assert property (@(posedge i_clk) disable iff (i_rst)
        (in_st_r == ST_ARMED && i_in_src == 3'(SRC_EXTERNAL) && !(i_ext_trig && !$past(i_ext_trig)))
        |=> in_st_r != ST_RUN) else $error("external trigger fired without a rising edge");
    a_sw_start: assert property (@(posedge i_clk) disable iff (i_rst)
        (in_st_r == ST_ARMED && i_in_src == 3'(SRC_SOFTWARE) && i_start_in && !i_stop)
        |=> in_st_r == ST_RUN) else $error("software start did not run input");
    a_idle_ignore: assert property (@(posedge i_clk) disable iff (i_rst)
        (in_st_r == ST_IDLE && !i_arm_in) |=> in_st_r == ST_IDLE) else $error("idle input left idle");
    a_nowrap_stop: assert property (@(posedge i_clk) disable iff (i_rst)
        in_done && !i_stop |=> in_st_r == ST_IDLE) else $error("non-wrap input did not stop when full");
    a_wrap_run: assert property (@(posedge i_clk) disable iff (i_rst)
        (in_st_r == ST_RUN && i_in_wrap && !i_stop) |=> in_st_r == ST_RUN) else $error("wrap input stopped");
    a_out_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
        (out_step && i_out_wrap && op_r == i_out_last) |=> op_r == '0) else $error("output pointer did not wrap");
    a_out_stop: assert property (@(posedge i_clk) disable iff (i_rst)
        out_done && !i_stop |=> out_st_r == ST_IDLE) else $error("non-wrap output did not stop");
    a_dl_start: assert property (@(posedge i_clk) disable iff (i_rst)
        i_dl_start |=> rp_r == '0 && dl_act_r) else $error("download not started at buffer start");
    a_lan_tx: assert property (@(posedge i_clk) disable iff (i_rst)
        (in_trig && i_lan_out_en) |=> o_lan_tx_valid && o_lan_tx_num == $past(i_lan_out_sel))
        else $error("lan event not broadcast");
    c_in_run: cover property (@(posedge i_clk) in_st_r == ST_ARMED ##1 in_st_r == ST_RUN);
    c_in_full: cover property (@(posedge i_clk) in_done);
    c_out_wrap: cover property (@(posedge i_clk) out_step && i_out_wrap && op_r == i_out_last);
    c_dl_done: cover property (@(posedge i_clk) o_dl_done);
endmodule // acq_trigger_buffer_control

// ### testbench/sample_source.sv
// Sample stream source standing in for the converters that feed the block.
module sample_source
    import acq_trig_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_go,
    input wire logic [15:0] i_limit,
    output logic [15:0] o_sent,
    // Stream
    output logic o_valid,
    output logic [23:0] o_data,
    input wire logic i_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // Word order
    // ------
    // Words carry their own index, so the bench knows what each address must hold.
    wire logic more = i_go && ((o_sent + 16'h0001) < i_limit);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_sent <= 16'h0000;
            o_valid <= 1'b0;
            o_data <= 24'h000000;
        end else if (o_valid && i_ready) begin
            o_sent <= o_sent + 16'h0001;
            o_valid <= more;
            o_data <= more ? {8'h00, o_sent + 16'h0001} : ~o_data;
        end else if (!o_valid && i_go && o_sent < i_limit) begin
            o_valid <= 1'b1;
            o_data <= {8'h00, o_sent};
        end else if (!o_valid) begin
            o_data <= ~o_data;
        end
    end
endmodule // sample_source

// ### testbench/acq_trigger_buffer_control_bench.sv
// Self-checking bench for the trigger and buffer control block.
`include "acq_trig_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module acq_trigger_buffer_control_bench
    import acq_trig_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] ARM_IN = 7'h40, ARM_OUT = 7'h20, START_IN = 7'h10, START_OUT = 7'h08;
    localparam logic [6:0] STOP = 7'h04, DL_START = 7'h02, DL_STOP = 7'h01;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [2:0] in_src = 3'h0, out_src = 3'h0, tbus_sel = 3'h2, lan_sel = 3'h5, lan_num = 3'h0;
    logic in_wrap = 1'b0, out_wrap = 1'b0, ext_trig = 1'b0, lan_evt = 1'b0, t_en = 1'b1, l_en = 1'b1;
    logic [13:0] ch1 = 14'h0000;
    logic [5:0] tbus_in = 6'h00;
    logic [6:0] cmds = 7'h00;
    logic [3:0] d_set = 4'h0, d_val = 4'h0;
    logic wav_we = 1'b0, tick = 1'b0, go = 1'b0;
    logic [9:0] wav_addr = 10'h000;
    logic [23:0] wav_data = 24'h000000;
    logic [15:0] limit = 16'h0000, sent;
    logic s_valid, s_ready, dac_valid, dl_valid, dl_done, lan_tx, in_full;
    logic [23:0] s_data, dac_data, dl_data;
    logic [3:0] closed;
    logic [5:0] t_out, t_oe_n, t_seen, oe_seen;
    logic [2:0] lan_tx_num, lan_seen;
    logic [1:0] in_state, out_state;
    logic [23:0] dacq[$], dlq[$];
    logic dl_end = 1'b0;
    int n_tests = 0, n_mismatch = 0, n_tbus = 0, n_lan = 0, bad, k;
    always #5 i_clk = ~i_clk;
    acq_trigger_buffer_control u_acq_trigger_buffer_control (
        .i_clk(i_clk), .i_rst(i_rst), .i_in_src(in_src), .i_out_src(out_src),
        .i_tbus_sel(tbus_sel), .i_lan_sel(lan_sel), .i_tbus_out_sel(3'h4), .i_tbus_out_en(t_en),
        .i_lan_out_sel(3'h6), .i_lan_out_en(l_en), .i_level_mv(14'h03E8), .i_in_wrap(in_wrap),
        .i_out_wrap(out_wrap), .i_chan_en(8'h0F), .i_out_last(10'h003),
        .i_arm_in(cmds[6]), .i_arm_out(cmds[5]), .i_start_in(cmds[4]), .i_start_out(cmds[3]),
        .i_stop(cmds[2]), .i_dl_start(cmds[1]), .i_dl_stop(cmds[0]), .i_ext_trig(ext_trig),
        .i_ch1_mv(ch1), .i_tbus_in(tbus_in), .i_lan_evt_valid(lan_evt), .i_lan_evt_num(lan_num),
        .i_smp_valid(s_valid), .i_smp_data(s_data), .o_smp_ready(s_ready), .i_wav_we(wav_we),
        .i_wav_addr(wav_addr), .i_wav_data(wav_data), .i_dac_tick(tick), .o_dac_data(dac_data),
        .o_dac_valid(dac_valid), .o_dl_valid(dl_valid), .o_dl_data(dl_data), .o_dl_done(dl_done),
        .i_dout_set(d_set), .i_dout_val(d_val), .o_dout_closed(closed), .o_tbus_out(t_out),
        .o_tbus_oe_n(t_oe_n), .o_lan_tx_valid(lan_tx), .o_lan_tx_num(lan_tx_num),
        .o_in_state(in_state), .o_out_state(out_state), .o_in_full(in_full));
    sample_source u_sample_source (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_limit(limit),
        .o_sent(sent), .o_valid(s_valid), .o_data(s_data), .i_ready(s_ready));
    // ------
    // Monitors and shared tasks
    // ------
    // Pulses stand one cycle, so they are caught at the falling edge of that cycle.
    always @(negedge i_clk) begin
        if (t_out !== 6'h00) begin
            n_tbus++;
            t_seen = t_out;
            oe_seen = t_oe_n;
        end
        if (lan_tx === 1'b1) begin
            n_lan++;
            lan_seen = lan_tx_num;
        end
        if (dac_valid === 1'b1) dacq.push_back(dac_data);
        if (dl_valid === 1'b1) dlq.push_back(dl_data);
        if (dl_done === 1'b1) dl_end = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic cmd(input logic [6:0] m);
        cmds <= m;
        cyc(1);
        cmds <= 7'h00;
        cyc(1);
    endtask
    task automatic wait_st(input bit o, input logic [1:0] e);
        int w;
        w = 0;
        while ((o ? out_state : in_state) !== e && w < 30) begin
            cyc(1);
            w++;
        end
        `CHK(o ? out_state : in_state, e)
    endtask
    task automatic do_reset();
        i_rst <= 1'b1;
        cyc(4);
        i_rst <= 1'b0;
        cyc(3);
    endtask
    task automatic lan_pulse(input logic [2:0] n);
        lan_evt <= 1'b1;
        lan_num <= n;
        cyc(1);
        lan_evt <= 1'b0;
    endtask
    task automatic download(input int stop_at);
        dlq.delete();
        dl_end = 1'b0;
        cmd(DL_START);
        for (int w = 0; w < 1100 && !dl_end; w++) begin
            if (w == stop_at) cmd(DL_STOP);
            else cyc(1);
        end
        cyc(4);
    endtask
    task automatic trig_case(input logic [2:0] s);
        // External input is high before arming: a level alone must not fire.
        in_src <= s;
        ext_trig <= (s == 3'h1);
        cyc(1);
        cmd(ARM_IN);
        wait_st(0, 2'h1);
        if (s == 3'h2) ch1 <= 14'h03E8;
        if (s == 3'h3) tbus_in <= 6'h3B;
        if (s == 3'h4) lan_pulse(3'h2);
        cyc(4);
        `CHK(in_state, 2'h1)
        ext_trig <= 1'b0;
        ch1 <= 14'h03E9;
        tbus_in <= 6'h3F;
        cyc(2);
        ext_trig <= 1'b1;
        if (s == 3'h4) lan_pulse(3'h5);
        wait_st(0, 2'h2);
        cmd(STOP);
        wait_st(0, 2'h0);
        ext_trig <= 1'b0;
        ch1 <= 14'h0000;
        tbus_in <= 6'h00;
    endtask
    task automatic out_case(input logic w, input int n);
        out_wrap <= w;
        in_src <= 3'h1;
        dacq.delete();
        cmd(ARM_OUT | ARM_IN);
        wait_st(1, 2'h1);
        cmd(START_OUT);
        wait_st(1, 2'h2);
        `CHK(in_state, 2'h1)
        repeat (n) begin
            tick <= 1'b1;
            cyc(1);
            tick <= 1'b0;
            cyc(3);
        end
        `CHK(dacq.size(), w ? n : 4)
        for (int j = 0; j < dacq.size(); j++) `CHK(dacq[j], 24'hA00000 + 24'(j % 4))
        `CHK(out_state, w ? 2'h2 : 2'h0)
        cmd(STOP);
        wait_st(1, 2'h0);
    endtask
    task automatic complete_run();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------
    // Test sequence
    // ------
    initial begin
        do_reset();
        `CHK(t_oe_n, 6'h2F)
        d_set <= 4'h5;
        d_val <= 4'h1;
        cyc(1);
        d_set <= 4'h0;
        cyc(3);
        `CHK(closed, 4'h1)
        d_set <= 4'h2;
        d_val <= 4'hF;
        cyc(1);
        d_set <= 4'h0;
        cyc(3);
        `CHK(closed, 4'h3)
        cmd(START_IN);
        cyc(4);
        `CHK(in_state, 2'h0)
        cmd(ARM_IN);
        wait_st(0, 2'h1);
        cmd(START_IN);
        wait_st(0, 2'h2);
        `CHK(t_seen, 6'h10)
        `CHK(oe_seen[4], 1'b0)
        `CHK(lan_seen, 3'h6)
        cmd(STOP);
        wait_st(0, 2'h0);
        for (int s = 1; s < 5; s++) trig_case(3'(s));
        `CHK(n_tbus, 5)
        `CHK(n_lan, 5)
        for (int j = 0; j < 4; j++) begin
            wav_we <= 1'b1;
            wav_addr <= 10'(j);
            wav_data <= 24'hA00000 + 24'(j);
            cyc(1);
        end
        wav_we <= 1'b0;
        out_case(1'b0, 6);
        out_case(1'b1, 6);
        // Non-wrap fill: four channels make the buffer end fall on a scan end.
        do_reset();
        in_src <= 3'h0;
        limit <= 16'h07D0;
        cmd(ARM_IN);
        cmd(START_IN);
        go <= 1'b1;
        for (k = 0; k < 1500 && in_full !== 1'b1; k++) cyc(1);
        `CHK(in_full, 1'b1)
        wait_st(0, 2'h0);
        go <= 1'b0;
        download(2000);
        `CHK(dlq.size(), 1024)
        bad = 0;
        for (int j = 0; j < dlq.size(); j++) if (dlq[j] !== 24'(j)) bad++;
        `CHK(bad, 0)
        do_reset();
        in_wrap <= 1'b1;
        limit <= 16'h0406;
        cmd(ARM_IN);
        cmd(START_IN);
        go <= 1'b1;
        cyc(1200);
        `CHK(sent, 16'h0406)
        `CHK(in_state, 2'h2)
        cmd(STOP);
        wait_st(0, 2'h0);
        download(2000);
        `CHK(dlq.size(), 1024)
        `CHK(dlq[0], 24'h000400)
        `CHK(dlq[6], 24'h000006)
        download(8);
        `CHK(dlq.size() < 20, 1'b1)
        complete_run();
    end
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule // acq_trigger_buffer_control_bench
